/* logic/wdrc_top.sv */
// watchdog timer, enable key, reset-pin key and reset sequencing
// assumes a classic wishbone master on clk_i, sub clocks and the shared
// reset pin arrive asynchronously, rst_i is the power-on reset
//
// Functional notes
// - counter ticks only on selected sub clock
// - period field selects two-power time-out
// - key 10101 stops, 01010 runs watchdog
// - bad enable key resets after 2-3 rc; the logic resets on the second rc edge, 1-2 rc later
// - bad key sets flag, software clears
// - power-on: key enabled, period 011
// - normal time-out: device reset, flag set
// - low-power time-out: clear pc and sp
// - pin, key reset, clear, halt clear count
// - pin key selects io or reset pin
// - bad pin key resets, sets flag
// - power-on: pin key selects io
// - enabled pin low resets device
// - extra delay after reset release
// - power-on presets ports high, pc zero
// - flag bits six to four read zero
// - time-out sets power-down flag when sleeping
// - deep sleep, watchdog off: clear and stop
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "wdrc_cfg.svh"

module wdrc_top import wdrc_pkg::*; #(
  parameter int REL_DLY_CYC = `WDRC_REL_DLY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic xtal_sub_clk_i,
  input wire logic rc_sub_clk_i,
  input wire logic sub_src_xtal_i,
  input wire logic reset_pin_n_i,
  input wire logic wd_clear_i,
  input wire logic halt_i,
  input wire logic idle_en_i,
  input wire logic wake_i,
  output logic dev_reset_o,
  output logic port_preset_o,
  output logic pc_sp_clear_o,
  output logic pin_is_reset_o,
  output logic idle_sys_keep_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers: 0 crystal sub clock, 1 rc sub clock, 2 reset pin
  // ----------------------------------------------------------------------
  logic [2:0] in_raw;
  logic [2:0] filt_r;
  logic [2:0] rise_r;
  assign in_raw = {reset_pin_n_i, rc_sub_clk_i, xtal_sub_clk_i};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic [2:0] sh_r;
      logic filt_nxt;
      // a change is taken only when the second and third stage agree
      always_comb begin
        filt_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : filt_r[g];
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sh_r <= 3'h7;
          filt_r[g] <= 1'b1;
          rise_r[g] <= 1'b0;
        end else begin
          sh_r <= {sh_r[1:0], in_raw[g]};
          filt_r[g] <= filt_nxt;
          rise_r[g] <= filt_nxt & ~filt_r[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  logic [7:0] wdt_ctrl_r, wdt_ctrl_nxt;
  logic [7:0] pin_key_r, pin_key_nxt;
  logic wkey_flag_r, wkey_flag_nxt;
  logic pkey_flag_r, pkey_flag_nxt;
  logic syskeep_r, syskeep_nxt;
  logic to_r, to_nxt;
  logic pdown_r, pdown_nxt;
  logic [17:0] cnt_r, cnt_nxt;
  logic lowpwr_r, lowpwr_nxt;
  logic stopped_r, stopped_nxt;
  logic [1:0] wkey_dly_r, wkey_dly_nxt;
  logic [1:0] pkey_dly_r, pkey_dly_nxt;
  wdrc_rst_state_e st_r, st_nxt;
  logic [15:0] dly_r, dly_nxt;
  logic dev_reset_nxt, pcsp_nxt;
  logic ack_nxt;
  logic [31:0] rdat_nxt;

  logic [4:0] key;
  logic wkey_bad, pkey_bad, wdt_on, sub_tick, pin_low, timeout;
  logic wkey_fire, pkey_fire, req, wr_go;

  function automatic logic [17:0] period_mask(input logic [2:0] sel);
    case (sel)
      3'h0: period_mask = 18'h000ff;
      3'h1: period_mask = 18'h003ff;
      3'h2: period_mask = 18'h00fff;
      3'h3: period_mask = 18'h03fff;
      3'h4: period_mask = 18'h07fff;
      3'h5: period_mask = 18'h0ffff;
      3'h6: period_mask = 18'h1ffff;
      default: period_mask = 18'h3ffff;
    endcase
  endfunction

  assign key = wdt_ctrl_r[`WDRC_KEY_MSB:`WDRC_KEY_LSB];
  assign wdt_on = (key == `WDRC_KEY_ON);
  assign wkey_bad = !wdt_on && (key != `WDRC_KEY_OFF);
  assign pkey_bad = (pin_key_r != `WDRC_PIN_IO) && (pin_key_r != `WDRC_PIN_RESET);
  assign sub_tick = sub_src_xtal_i ? rise_r[0] : rise_r[1];
  // reset pin acts only in reset mode
  assign pin_low = (pin_key_r == `WDRC_PIN_RESET) && !filt_r[2];
  // time-out when the next tick reaches the selected power
  assign timeout = wdt_on && !stopped_r && sub_tick
                   && (cnt_r == period_mask(wdt_ctrl_r[`WDRC_PER_MSB:0]));
  // second rc edge after the bad key lands 1-2 rc cycles later
  assign wkey_fire = wkey_bad && rise_r[1] && (wkey_dly_r == `WDRC_KEY_DLY_EDGES - 2'h1);
  // same delay for the pin key
  assign pkey_fire = pkey_bad && rise_r[1] && (pkey_dly_r == `WDRC_KEY_DLY_EDGES - 2'h1);
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_go = req && wb_we_i && wb_ack_o && wb_sel_i[0];

  // ----------------------------------------------------------------------
  // wishbone answer: ack one cycle after the request, one cycle wide
  // ----------------------------------------------------------------------
  always_comb begin
    ack_nxt = req && !wb_ack_o;
    rdat_nxt = 32'h0;
    if (wb_adr_i == `WDRC_OFS_WDT_CTRL) begin
      rdat_nxt[7:0] = wdt_ctrl_r;
    end else if (wb_adr_i == `WDRC_OFS_FLAGS) begin
      // bits six to four and the undervoltage flags read zero
      rdat_nxt[`WDRC_FLG_SYSKEEP] = syskeep_r;
      rdat_nxt[`WDRC_FLG_PKEY] = pkey_flag_r;
      rdat_nxt[`WDRC_FLG_WKEY] = wkey_flag_r;
    end else if (wb_adr_i == `WDRC_OFS_PIN_KEY) begin
      rdat_nxt[7:0] = pin_key_r;
    end else if (wb_adr_i == `WDRC_OFS_STATUS) begin
      rdat_nxt[`WDRC_STS_TO] = to_r;
      rdat_nxt[`WDRC_STS_PDOWN] = pdown_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= ack_nxt;
      wb_dat_o <= rdat_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // watchdog, keys, flags and reset sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    wdt_ctrl_nxt = wdt_ctrl_r;
    pin_key_nxt = pin_key_r;
    wkey_flag_nxt = wkey_flag_r;
    pkey_flag_nxt = pkey_flag_r;
    syskeep_nxt = syskeep_r;
    to_nxt = to_r;
    pdown_nxt = pdown_r;
    cnt_nxt = cnt_r;
    lowpwr_nxt = lowpwr_r;
    stopped_nxt = stopped_r;
    st_nxt = st_r;
    dly_nxt = dly_r;
    pcsp_nxt = 1'b0;
    wkey_dly_nxt = wkey_bad ? (wkey_dly_r + {1'b0, rise_r[1]}) : 2'h0;
    pkey_dly_nxt = pkey_bad ? (pkey_dly_r + {1'b0, rise_r[1]}) : 2'h0;

    if (wr_go) begin
      if (wb_adr_i == `WDRC_OFS_WDT_CTRL) begin
        wdt_ctrl_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i == `WDRC_OFS_PIN_KEY) begin
        pin_key_nxt = wb_dat_i[7:0];
      end else if (wb_adr_i == `WDRC_OFS_FLAGS) begin
        syskeep_nxt = wb_dat_i[`WDRC_FLG_SYSKEEP];
        // writing zero clears, a one leaves the flag alone
        if (!wb_dat_i[`WDRC_FLG_WKEY]) begin
          wkey_flag_nxt = 1'b0;
        end
        if (!wb_dat_i[`WDRC_FLG_PKEY]) begin
          pkey_flag_nxt = 1'b0;
        end
      end
    end

    // count sub clock ticks while enabled and not stopped
    if (wdt_on && !stopped_r && sub_tick) begin
      cnt_nxt = cnt_r + 18'h1;
    end
    if (wd_clear_i) begin
      cnt_nxt = 18'h0;
    end
    if (halt_i && !lowpwr_r) begin
      // halt clears the count and enters low power
      cnt_nxt = 18'h0;
      lowpwr_nxt = 1'b1;
      pdown_nxt = 1'b1;
      to_nxt = 1'b0;
      // deep sleep with watchdog off stops the count
      stopped_nxt = !idle_en_i && !wdt_on;
    end
    if (wake_i) begin
      lowpwr_nxt = 1'b0;
      stopped_nxt = 1'b0;
    end

    if (timeout) begin
      cnt_nxt = 18'h0;
      to_nxt = 1'b1;
      if (lowpwr_r) begin
        // low-power time-out clears pc and sp only, wakes up
        pcsp_nxt = 1'b1;
        pdown_nxt = 1'b1;
        lowpwr_nxt = 1'b0;
      end
    end

    // set wins over a simultaneous software clear
    if (wkey_fire) begin
      wkey_flag_nxt = 1'b1;
    end
    if (pkey_fire) begin
      pkey_flag_nxt = 1'b1;
    end

    // causes hold the device in reset, then a fixed delay
    case (st_r)
      WDRC_RUN: begin
        if (wkey_fire || pkey_fire || pin_low || (timeout && !lowpwr_r)) begin
          st_nxt = WDRC_HOLD;
        end
      end
      WDRC_HOLD: begin
        if (!pin_low) begin
          st_nxt = WDRC_DELAY;
          dly_nxt = 16'(REL_DLY_CYC - 1);
        end
      end
      WDRC_DELAY: begin
        // a new cause during the delay must not be lost
        if (pin_low || wkey_fire || pkey_fire || (timeout && !lowpwr_r)) begin
          st_nxt = WDRC_HOLD;
        end else if (dly_r == 16'h0) begin
          st_nxt = WDRC_RUN;
        end else begin
          dly_nxt = dly_r - 16'h1;
        end
      end
      default: begin
        st_nxt = WDRC_RUN;
      end
    endcase

    if (st_r == WDRC_HOLD) begin
      // device reset restores keys and clears the count
      cnt_nxt = 18'h0;
      wdt_ctrl_nxt = `WDRC_POR_WDT_CTRL;
      // a pin reset keeps the reset function until the pin is released
      if (!pin_low) begin
        pin_key_nxt = `WDRC_POR_PIN_KEY;
      end
      lowpwr_nxt = 1'b0;
      stopped_nxt = 1'b0;
    end
    dev_reset_nxt = (st_nxt != WDRC_RUN);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_ctrl_r <= `WDRC_POR_WDT_CTRL;
      pin_key_r <= `WDRC_POR_PIN_KEY;
      wkey_flag_r <= 1'b0;
      pkey_flag_r <= 1'b0;
      syskeep_r <= 1'b0;
      to_r <= 1'b0;
      pdown_r <= 1'b0;
      cnt_r <= 18'h0;
      lowpwr_r <= 1'b0;
      stopped_r <= 1'b0;
      wkey_dly_r <= 2'h0;
      pkey_dly_r <= 2'h0;
      st_r <= WDRC_DELAY;
      dly_r <= 16'(REL_DLY_CYC - 1);
      dev_reset_o <= 1'b1;
      pc_sp_clear_o <= 1'b0;
      // ports preset high while the power-on reset lasts
      port_preset_o <= 1'b1;
      pin_is_reset_o <= 1'b0;
      idle_sys_keep_o <= 1'b0;
    end else begin
      wdt_ctrl_r <= wdt_ctrl_nxt;
      pin_key_r <= pin_key_nxt;
      wkey_flag_r <= wkey_flag_nxt;
      pkey_flag_r <= pkey_flag_nxt;
      syskeep_r <= syskeep_nxt;
      to_r <= to_nxt;
      pdown_r <= pdown_nxt;
      cnt_r <= cnt_nxt;
      lowpwr_r <= lowpwr_nxt;
      stopped_r <= stopped_nxt;
      wkey_dly_r <= wkey_dly_nxt;
      pkey_dly_r <= pkey_dly_nxt;
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      dev_reset_o <= dev_reset_nxt;
      pc_sp_clear_o <= pcsp_nxt;
      port_preset_o <= dev_reset_nxt;
      pin_is_reset_o <= (pin_key_nxt == `WDRC_PIN_RESET);
      idle_sys_keep_o <= syskeep_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_key_fire_reset: assert property (
    wkey_fire |=> dev_reset_o && wkey_flag_r && st_r == WDRC_HOLD ##1
      wdt_ctrl_r == `WDRC_POR_WDT_CTRL)
    else $error("bad enable key did not reset");
  chk_pkey_flag_set: assert property (
    pkey_fire |=> pkey_flag_r && dev_reset_o)
    else $error("bad pin key did not set flag");
  chk_flag_hold: assert property (
    $rose(wkey_flag_r) |-> $past(wkey_fire))
    else $error("key flag set without cause");
  chk_off_no_count: assert property (
    (key == `WDRC_KEY_OFF) && !wd_clear_i && !halt_i |=> $stable(cnt_r) || cnt_r == 18'h0)
    else $error("disabled watchdog counted");
  chk_normal_timeout: assert property (
    timeout && !lowpwr_r |=> to_r && dev_reset_o)
    else $error("normal time-out did not reset");
  chk_sleep_timeout: assert property (
    timeout && lowpwr_r |=> pc_sp_clear_o && to_r && pdown_r && !dev_reset_o)
    else $error("low-power time-out handled wrong");
  chk_clear_count: assert property (
    wd_clear_i && !timeout |=> cnt_r == 18'h0)
    else $error("clear instruction missed");
  chk_pin_reset: assert property (
    pin_low |=> dev_reset_o [*2])
    else $error("reset pin ignored");
  chk_reset_delay: assert property (
    st_r == WDRC_HOLD && !pin_low |=> dev_reset_o && dly_r == 16'(REL_DLY_CYC - 1))
    else $error("release delay not loaded");
  chk_delay_hold: assert property (
    st_r == WDRC_DELAY && dly_r != 16'h0 |=> dev_reset_o)
    else $error("released before delay ran out");
  chk_count_range: assert property (
    wdt_on && !stopped_r |-> cnt_r <= period_mask(wdt_ctrl_r[`WDRC_PER_MSB:0]))
    else $error("count passed period");
  chk_deep_stop: assert property (
    stopped_r && !wd_clear_i |=> cnt_r == 18'h0)
    else $error("stopped watchdog counted");

endmodule

/* shared/wdrc_cfg.svh */
// register offsets, field positions, reset values and timing counts of the
// watchdog and reset-pin control block; definitions only
`ifndef WDRC_CFG_SVH
`define WDRC_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets (word aligned)
// ----------------------------------------------------------------------
`define WDRC_OFS_WDT_CTRL 4'h0
`define WDRC_OFS_FLAGS 4'h4
`define WDRC_OFS_PIN_KEY 4'h8
`define WDRC_OFS_STATUS 4'hc

// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define WDRC_KEY_MSB 7
`define WDRC_KEY_LSB 3
`define WDRC_PER_MSB 2
`define WDRC_KEY_OFF 5'h15
`define WDRC_KEY_ON 5'h0a
`define WDRC_PIN_IO 8'h55
`define WDRC_PIN_RESET 8'haa
`define WDRC_FLG_WKEY 0
`define WDRC_FLG_PKEY 3
`define WDRC_FLG_SYSKEEP 7
`define WDRC_STS_TO 0
`define WDRC_STS_PDOWN 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define WDRC_POR_WDT_CTRL 8'h53
`define WDRC_POR_PIN_KEY 8'h55

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WDRC_CLK_NS 50
`define WDRC_REL_DLY_NS 1000
`define WDRC_REL_DLY_CYC ((`WDRC_REL_DLY_NS + `WDRC_CLK_NS - 1) / `WDRC_CLK_NS)
`define WDRC_KEY_DLY_EDGES 2'h2

`endif

/* shared/wdrc_pkg.sv */
// types shared by the watchdog and reset-pin control block
// assumes wdrc_cfg.svh is included by the files that need the constants
package wdrc_pkg;

  // ----------------------------------------------------------------------
  // device reset sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    WDRC_RUN = 2'b00,
    WDRC_HOLD = 2'b01,
    WDRC_DELAY = 2'b10
  } wdrc_rst_state_e;

endpackage

/* verification/wdrc_far_side.sv */
// far side of the watchdog block: the two free-running sub clock oscillators
// and the external reset network on the shared pin
// assumes the bench asks for a pin pull-down through pull_low_i
`timescale 1ns/1ns
module wdrc_far_side #(
  parameter int RC_HALF = 200,
  parameter int XTAL_HALF = 300
) (
  input wire logic pull_low_i,
  output logic rc_clk_o,
  output logic xtal_clk_o,
  output logic reset_pin_n_o
);
  // ----------------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------------
  // periods differ so the source select shows up in the time-out length
  initial begin
    rc_clk_o = 1'b0;
    xtal_clk_o = 1'b0;
  end
  always #RC_HALF rc_clk_o = ~rc_clk_o;
  always #XTAL_HALF xtal_clk_o = ~xtal_clk_o;
  // ----------------------------------------------------------------------
  // reset network
  // ----------------------------------------------------------------------
  // pull-up resistor holds the pin high unless the switch pulls it low
  assign reset_pin_n_o = pull_low_i ? 1'b0 : 1'b1;
endmodule

/* verification/wdrc_top_tb.sv */
// self-checking bench for the watchdog and reset-pin control block
// assumes a one-cycle ack on the bus and a short reset delay parameter
`timescale 1ns/1ns
`include "wdrc_cfg.svh"
module wdrc_top_tb;
  localparam int LP = 8;
  localparam int XP = 12;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clr = 0, halt = 0;
  logic idle = 1, src = 0, pull = 0, wake = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o, q;
  logic ack, dev, pre, pcsp, pinr, keep, rcc, xtc, pin_n;
  int fail_count = 0, num_checks = 0;

  always #25 clk_i = ~clk_i;

  wdrc_far_side wdrc_far_side_inst (.pull_low_i(pull), .rc_clk_o(rcc),
    .xtal_clk_o(xtc), .reset_pin_n_o(pin_n));
  wdrc_top #(.REL_DLY_CYC(2)) wdrc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .xtal_sub_clk_i(xtc), .rc_sub_clk_i(rcc), .sub_src_xtal_i(src),
    .reset_pin_n_i(pin_n), .wd_clear_i(clr), .halt_i(halt), .idle_en_i(idle),
    .wake_i(wake), .dev_reset_o(dev), .port_preset_o(pre),
    .pc_sp_clear_o(pcsp), .pin_is_reset_o(pinr), .idle_sys_keep_o(keep));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ack is registered, so reading it at the edge gives the pre-edge value
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(q, {24'h0, exp});
  endtask

  // 0 clear instruction, 1 halt, 2 wake-up
  task automatic pulse(input logic [1:0] k);
    @(posedge clk_i);
    if (k == 2'h1) halt <= 1'b1;
    else if (k == 2'h2) wake <= 1'b1;
    else clr <= 1'b1;
    @(posedge clk_i);
    halt <= 1'b0;
    clr <= 1'b0;
    wake <= 1'b0;
  endtask

  task automatic run_wait();
    int n;
    n = 0;
    while (dev !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check({31'h0, dev}, 32'h0);
  endtask

  // the event must not come before lo cycles and must come by hi
  task automatic expect_event(input bit pc, input int lo, input int hi);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < hi) begin
      @(posedge clk_i);
      n++;
      hit = pc ? (pcsp === 1'b1) : (dev === 1'b1);
    end
    check({31'h0, hit && n >= lo}, 32'h1);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(60000 * 50);
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    check({31'h0, pre}, 32'h1);
    rst_i <= 1'b0;
    run_wait();
    rd(`WDRC_OFS_WDT_CTRL, `WDRC_POR_WDT_CTRL);
    rd(`WDRC_OFS_PIN_KEY, `WDRC_POR_PIN_KEY);
    rd(`WDRC_OFS_FLAGS, 8'h00);
    rd(`WDRC_OFS_STATUS, 8'h00);
    rd(4'h2, 8'h00);
    check({31'h0, pinr}, 32'h0);
    // disabled key: no time-out however long we wait
    xfer(1'b1, `WDRC_OFS_WDT_CTRL, {`WDRC_KEY_OFF, 3'h0});
    pulse(1'b0);
    repeat (3000) @(posedge clk_i);
    check({31'h0, dev}, 32'h0);
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, `WDRC_OFS_WDT_CTRL, {`WDRC_KEY_ON, p[2:0]});
      // refresh before the period runs out
      pulse(1'b0);
      repeat (2) begin
        repeat (1500) @(posedge clk_i);
        pulse(1'b0);
      end
      check({31'h0, dev}, 32'h0);
      expect_event(1'b0, (LP << (8 + 2 * p)) - 20, (LP << (8 + 2 * p)) + 30);
      run_wait();
      rd(`WDRC_OFS_STATUS, 8'h01);
      rd(`WDRC_OFS_WDT_CTRL, `WDRC_POR_WDT_CTRL);
    end
    src <= 1'b1;
    xfer(1'b1, `WDRC_OFS_WDT_CTRL, {`WDRC_KEY_ON, 3'h0});
    pulse(1'b0);
    expect_event(1'b0, 256 * XP - 20, 256 * XP + 30);
    run_wait();
    src <= 1'b0;
    xfer(1'b1, `WDRC_OFS_WDT_CTRL, {`WDRC_KEY_ON, 3'h0});
    pulse(1'b1);
    rd(`WDRC_OFS_STATUS, 8'h02);
    expect_event(1'b1, 256 * LP - 40, 256 * LP + 30);
    check({31'h0, dev}, 32'h0);
    rd(`WDRC_OFS_STATUS, 8'h03);
    // deep sleep with the watchdog off: count held until wake-up
    idle <= 1'b0;
    xfer(1'b1, `WDRC_OFS_WDT_CTRL, {`WDRC_KEY_OFF, 3'h0});
    pulse(2'h1);
    xfer(1'b1, `WDRC_OFS_WDT_CTRL, {`WDRC_KEY_ON, 3'h0});
    repeat (256 * LP + 100) @(posedge clk_i);
    check({31'h0, dev}, 32'h0);
    pulse(2'h2);
    expect_event(1'b0, 256 * LP - 20, 256 * LP + 30);
    run_wait();
    idle <= 1'b1;
    xfer(1'b1, `WDRC_OFS_WDT_CTRL, 8'h00);
    expect_event(1'b0, LP, 4 * LP + 10);
    run_wait();
    rd(`WDRC_OFS_FLAGS, 8'h01);
    rd(`WDRC_OFS_WDT_CTRL, `WDRC_POR_WDT_CTRL);
    xfer(1'b1, `WDRC_OFS_FLAGS, 8'h80);
    rd(`WDRC_OFS_FLAGS, 8'h80);
    check({31'h0, keep}, 32'h1);
    xfer(1'b1, `WDRC_OFS_PIN_KEY, `WDRC_PIN_RESET);
    repeat (2) @(posedge clk_i);
    check({31'h0, pinr}, 32'h1);
    pull <= 1'b1;
    repeat (10) @(posedge clk_i);
    check({31'h0, dev}, 32'h1);
    pull <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'h0, dev}, 32'h1);
    run_wait();
    rd(`WDRC_OFS_PIN_KEY, `WDRC_POR_PIN_KEY);
    xfer(1'b1, `WDRC_OFS_PIN_KEY, 8'h12);
    expect_event(1'b0, LP, 4 * LP + 10);
    run_wait();
    rd(`WDRC_OFS_FLAGS, 8'h88);
    test_done();
  end
endmodule
